/* flash_spi_asserts.sv */
// link checker: frame length, drive edges, pin ownership and idle release
// assumes the link interface signals and the system clock and reset of both ends
`timescale 1ns/1ps
module flash_spi_asserts
  import flash_spi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic host_io0_o,
  input wire logic host_io0_oe,
  input wire logic host_io1_o,
  input wire logic host_io1_oe,
  input wire logic dev_io0_o,
  input wire logic dev_io0_oe,
  input wire logic dev_io1_o,
  input wire logic dev_io1_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  logic [3:0] hi_q;
  logic [9:0] rise_q;
  logic sck_q;

  // cycles with select released, saturating
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_q <= 4'h0;
    end else if (!cs_n) begin
      hi_q <= 4'h0;
    end else if (hi_q != 4'hF) begin
      hi_q <= hi_q + 4'h1;
    end
  end

  // rising link clock edges within the current frame
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_q <= 1'b0;
      rise_q <= 10'h000;
    end else begin
      sck_q <= sck;
      rise_q <= cs_n ? 10'h000 : rise_q + 10'(sck && !sck_q);
    end
  end

  frame_bits_a: assert property ($rose(cs_n) |-> rise_q >= 8 && rise_q[1:0] == 2'b00)
    else $error("frame ended on a partial unit");
  oe_idle_a: assert property (hi_q >= 4'h8 |-> !dev_io0_oe && !dev_io1_oe)
    else $error("device drives data with select released");
  oe_in_frame_a: assert property ($rose(dev_io0_oe) || $rose(dev_io1_oe) |-> !cs_n)
    else $error("device began driving outside a frame");
  host_io0_fall_a: assert property
    (!cs_n && !$past(cs_n) && host_io0_oe && $changed(host_io0_o) |-> !sck)
    else $error("host changed io0 while clock high");
  host_io1_fall_a: assert property
    (!cs_n && !$past(cs_n) && host_io1_oe && $changed(host_io1_o) |-> !sck)
    else $error("host changed io1 while clock high");
  dev_drive_fall_a: assert property (dev_io1_oe && $past(dev_io1_oe) && $changed(dev_io1_o) |-> !sck)
    else $error("device changed io1 while clock high");
  io0_owner_a: assert property (dev_io0_oe |-> !host_io0_oe)
    else $error("both ends drive io0");
  io1_owner_a: assert property (host_io1_oe |-> !dev_io1_oe)
    else $error("both ends drive io1");
  sck_half_a: assert property (!cs_n && $changed(sck) |=> $stable(sck) [*8])
    else $error("link clock half period too short");

  cover property ($rose(dev_io0_oe));
  cover property ($rose(host_io1_oe));
  cover property ($rose(cs_n) && rise_q >= 10'd48);
endmodule

/* flash_spi_dev.sv */
// device end: command front end of the serial flash
// assumes link pins are asynchronous to sys_clk and the link clock is slow enough to oversample
`timescale 1ns/1ps
module flash_spi_dev
  import flash_spi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  spi_link_if.dev link,
  output logic op_start,
  output logic [7:0] op_code,
  output logic [ADDR_W-1:0] op_addr,
  output logic op_end,
  output logic op_abort,
  output logic op_ignored,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_req,
  input wire logic [7:0] rd_data,
  output logic busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DATA = 3'b100,
    ST_IGNORE = 3'b101
  } dev_state_t;

  dev_state_t state_q;
  logic [SYNC_STAGES-1:0] sync_q [4];
  logic [3:0] filt_q;
  logic sck_prev_q;
  logic [2:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  logic [7:0] op_q;
  logic [15:0] addr_hi_q;
  logic [2:0] out_cnt_q;
  logic [7:0] tx_q;
  logic [3:0] pins;
  logic cs_act;
  logic sck_f;
  logic rise;
  logic fall;
  logic din;
  logic [7:0] next_byte;
  logic [7:0] cur_byte;
  logic dual_in;
  logic dual_out;
  logic rd_op;

  assign pins = {link.io1, link.io0, link.sck, link.cs_n};

  // three-stage synchroniser; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          sync_q[gi] <= {SYNC_STAGES{gi == 0}};
          filt_q[gi] <= (gi == 0) ? 1'b1 : 1'b0;
        end else begin
          sync_q[gi] <= {sync_q[gi][SYNC_STAGES-2:0], pins[gi]};
          if (sync_q[gi][1] == sync_q[gi][2]) begin
            filt_q[gi] <= sync_q[gi][2];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= filt_q[1];
    end
  end

  // either idle level is fine: only edges inside the frame are used
  assign cs_act = ~filt_q[0];
  assign sck_f = filt_q[1];
  assign rise = cs_act & sck_f & ~sck_prev_q;
  assign fall = cs_act & ~sck_f & sck_prev_q;
  assign din = filt_q[2];
  assign next_byte = {sh_q[6:0], din};
  assign dual_in = (op_q == OPC_PROG_DUAL);
  assign dual_out = (op_q == OPC_READ_DUAL);
  assign rd_op = op_reads(op_q);
  assign cur_byte = (out_cnt_q == 3'd0) ? rd_data : tx_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      bit_q <= 3'd0;
      byte_q <= 2'd0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      addr_hi_q <= 16'h0000;
      op_start <= 1'b0;
      op_code <= 8'h00;
      op_addr <= 24'h00_0000;
      op_end <= 1'b0;
      op_abort <= 1'b0;
      op_ignored <= 1'b0;
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
      rd_req <= 1'b0;
      busy <= 1'b0;
    end else begin
      op_start <= 1'b0;
      op_end <= 1'b0;
      op_abort <= 1'b0;
      op_ignored <= 1'b0;
      wr_valid <= 1'b0;
      rd_req <= 1'b0;
      rd_req <= fall && (state_q == ST_DATA) && rd_op && (out_cnt_q == 3'd0);
      if (!cs_act) begin
        // deselect ends every frame; a frame cut short in opcode or address performs nothing
        case (state_q)
          ST_OPCODE, ST_ADDR: op_abort <= 1'b1;
          ST_DUMMY, ST_DATA: op_end <= 1'b1;
          default: op_abort <= 1'b0;
        endcase
        state_q <= ST_IDLE;
        busy <= 1'b0;
      end else if (state_q == ST_IDLE) begin
        state_q <= ST_OPCODE;
        bit_q <= 3'd0;
        busy <= 1'b1;
      end else if (rise) begin
        case (state_q)
          ST_OPCODE: begin
            sh_q <= next_byte;
            bit_q <= bit_q + 3'd1;
            if (bit_q == 3'd7) begin
              op_q <= next_byte;
              byte_q <= 2'd0;
              if (!op_supported(next_byte)) begin
                state_q <= ST_IGNORE;
                op_ignored <= 1'b1;
              end else if (op_has_addr(next_byte)) begin
                state_q <= ST_ADDR;
              end else begin
                state_q <= ST_DATA;
                op_start <= 1'b1;
                op_code <= next_byte;
                op_addr <= 24'h00_0000;
                rd_req <= op_reads(next_byte);
              end
            end
          end
          ST_ADDR: begin
            sh_q <= next_byte;
            bit_q <= bit_q + 3'd1;
            if (bit_q == 3'd7) begin
              addr_hi_q <= {addr_hi_q[7:0], next_byte};
              byte_q <= byte_q + 2'd1;
              if (byte_q == 2'(ADDR_BYTES - 1)) begin
                byte_q <= 2'd0;
                op_start <= 1'b1;
                op_code <= op_q;
                op_addr <= {addr_hi_q, next_byte} & ADDR_MASK;
                rd_req <= rd_op;
                state_q <= (op_dummy(op_q) != 2'd0) ? ST_DUMMY : ST_DATA;
              end
            end
          end
          ST_DUMMY: begin
            bit_q <= bit_q + 3'd1;
            if (bit_q == 3'd7) begin
              byte_q <= byte_q + 2'd1;
              if (byte_q == op_dummy(op_q) - 2'd1) begin
                state_q <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (!rd_op) begin
              if (dual_in) begin
                sh_q <= {sh_q[5:0], filt_q[3], din};
                bit_q <= bit_q + 3'd2;
                if (bit_q == 3'd6) begin
                  wr_valid <= 1'b1;
                  wr_data <= {sh_q[5:0], filt_q[3], din};
                end
              end else begin
                sh_q <= next_byte;
                bit_q <= bit_q + 3'd1;
                if (bit_q == 3'd7) begin
                  wr_valid <= 1'b1;
                  wr_data <= next_byte;
                end
              end
            end
          end
          ST_IGNORE: state_q <= ST_IGNORE;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // read data leaves on falling edges, two bits per edge in dual mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_cnt_q <= 3'd0;
      tx_q <= 8'h00;
      link.dev_io0_o <= 1'b0;
      link.dev_io0_oe <= 1'b0;
      link.dev_io1_o <= 1'b0;
      link.dev_io1_oe <= 1'b0;
    end else if (!cs_act || state_q != ST_DATA || !rd_op) begin
      out_cnt_q <= 3'd0;
      link.dev_io0_oe <= 1'b0;
      link.dev_io1_oe <= 1'b0;
    end else if (fall) begin
      link.dev_io1_oe <= 1'b1;
      link.dev_io1_o <= cur_byte[7];
      if (dual_out) begin
        link.dev_io0_oe <= 1'b1;
        link.dev_io0_o <= cur_byte[6];
        tx_q <= {cur_byte[5:0], 2'b00};
        out_cnt_q <= out_cnt_q + 3'd2;
      end else begin
        tx_q <= {cur_byte[6:0], 1'b0};
        out_cnt_q <= out_cnt_q + 3'd1;
      end
    end
  end
endmodule

/* flash_spi_host.sv */
// host end: master that frames one flash command per request
// assumes the device end answers within half a link clock period
`timescale 1ns/1ps
module flash_spi_host
  import flash_spi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  spi_link_if.host link,
  input wire logic mode3,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_opcode,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [LEN_W-1:0] cmd_len,
  output logic busy,
  output logic done,
  output logic wr_req,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_RUN = 2'b01,
    H_HOLD = 2'b10,
    H_DESEL = 2'b11
  } host_state_t;

  host_state_t state_q;
  logic [SYNC_STAGES-1:0] s0_q;
  logic [SYNC_STAGES-1:0] s1_q;
  logic f0_q;
  logic f1_q;
  logic [SCK_DIV_W-1:0] div_q;
  logic [CNT_W-1:0] rises_q;
  logic [CNT_W-1:0] total_q;
  logic [CNT_W-1:0] hdr_q;
  logic [47:0] hsh_q;
  logic [7:0] op_q;
  logic idle_lvl_q;
  logic [2:0] wcnt_q;
  logic [7:0] wtx_q;
  logic [2:0] rcnt_q;
  logic [7:0] rx_q;
  logic [CNT_W-1:0] hdr_d;
  logic [CNT_W-1:0] data_d;
  logic tick;
  logic dual;
  logic [7:0] wcur;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s0_q <= '1;
      s1_q <= '1;
      f0_q <= 1'b1;
      f1_q <= 1'b1;
    end else begin
      s0_q <= {s0_q[SYNC_STAGES-2:0], link.io0};
      s1_q <= {s1_q[SYNC_STAGES-2:0], link.io1};
      if (s0_q[1] == s0_q[2]) begin
        f0_q <= s0_q[2];
      end
      if (s1_q[1] == s1_q[2]) begin
        f1_q <= s1_q[2];
      end
    end
  end

  assign hdr_d = CNT_W'(8) + (op_has_addr(cmd_opcode) ? CNT_W'(24) : CNT_W'(0))
               + CNT_W'({op_dummy(cmd_opcode), 3'b000});
  assign data_d = (cmd_opcode == OPC_READ_DUAL || cmd_opcode == OPC_PROG_DUAL) ?
                  CNT_W'({cmd_len, 2'b00}) : CNT_W'({cmd_len, 3'b000});
  assign tick = (div_q == SCK_DIV_W'(SCK_HALF_CYC - 1));
  assign dual = (op_q == OPC_READ_DUAL) || (op_q == OPC_PROG_DUAL);
  assign wcur = (wcnt_q == 3'd0) ? wr_data : wtx_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= H_IDLE;
      div_q <= '0;
      rises_q <= '0;
      total_q <= '0;
      hdr_q <= '0;
      hsh_q <= '0;
      op_q <= 8'h00;
      idle_lvl_q <= 1'b0;
      wcnt_q <= 3'd0;
      wtx_q <= 8'h00;
      rcnt_q <= 3'd0;
      rx_q <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      wr_req <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      link.cs_n <= 1'b1;
      link.sck <= 1'b0;
      link.host_io0_o <= 1'b0;
      link.host_io0_oe <= 1'b0;
      link.host_io1_o <= 1'b0;
      link.host_io1_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      wr_req <= 1'b0;
      rd_valid <= 1'b0;
      div_q <= tick ? '0 : div_q + SCK_DIV_W'(1);
      case (state_q)
        H_IDLE: begin
          div_q <= '0;
          link.sck <= mode3;
          if (cmd_start) begin
            state_q <= H_RUN;
            busy <= 1'b1;
            op_q <= cmd_opcode;
            idle_lvl_q <= mode3;
            hdr_q <= hdr_d;
            total_q <= hdr_d + data_d;
            hsh_q <= {cmd_opcode, cmd_addr, 16'h0000};
            rises_q <= '0;
            wcnt_q <= 3'd0;
            rcnt_q <= 3'd0;
            wr_req <= ~op_reads(cmd_opcode) & (cmd_len != '0);
            link.cs_n <= 1'b0;
            link.host_io0_oe <= 1'b1;
            link.host_io0_o <= cmd_opcode[7];
          end
        end
        H_RUN: begin
          if (tick) begin
            link.sck <= ~link.sck;
            if (!link.sck) begin
              rises_q <= rises_q + CNT_W'(1);
              if (rises_q >= hdr_q && op_reads(op_q)) begin
                rx_q <= dual ? {rx_q[5:0], f1_q, f0_q} : {rx_q[6:0], f1_q};
                rcnt_q <= rcnt_q + (dual ? 3'd2 : 3'd1);
                if (rcnt_q == (dual ? 3'd6 : 3'd7)) begin
                  rd_valid <= 1'b1;
                  rd_data <= dual ? {rx_q[5:0], f1_q, f0_q} : {rx_q[6:0], f1_q};
                end
              end
              if (rises_q + CNT_W'(1) == total_q) begin
                state_q <= H_HOLD;
              end
            end else if (rises_q != '0) begin
              // the leading fall of a mode 3 frame moves no data
              if (rises_q < hdr_q) begin
                hsh_q <= {hsh_q[46:0], 1'b0};
                link.host_io0_o <= hsh_q[46];
              end else if (op_reads(op_q)) begin
                link.host_io0_oe <= ~dual;
                link.host_io0_o <= 1'b0;
              end else begin
                wr_req <= (wcnt_q == 3'd0);
                link.host_io1_oe <= dual;
                link.host_io1_o <= wcur[7];
                link.host_io0_o <= dual ? wcur[6] : wcur[7];
                wtx_q <= dual ? {wcur[5:0], 2'b00} : {wcur[6:0], 1'b0};
                wcnt_q <= wcnt_q + (dual ? 3'd2 : 3'd1);
              end
            end
          end
        end
        H_HOLD: begin
          if (tick) begin
            link.sck <= idle_lvl_q;
            state_q <= H_DESEL;
          end
        end
        H_DESEL: begin
          if (tick) begin
            link.cs_n <= 1'b1;
            link.host_io0_oe <= 1'b0;
            link.host_io1_oe <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end
endmodule

/* flash_spi_pkg.sv */
// constants, opcodes and decode functions shared by both ends of the serial flash link
// assumes both ends run on the same 25 MHz system clock domain style
package flash_spi_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 24;
  localparam int ADDR_USED_W = 22;
  localparam int SYNC_STAGES = 3;
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int SCK_HALF_NS = 480;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int SCK_DIV_W = 5;
  localparam int LEN_W = 9;
  localparam int CNT_W = 13;
  localparam int ADDR_BYTES = 3;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 24'h3F_FFFF;
  localparam logic [7:0] OPC_READ_FAST2 = 8'h1B;
  localparam logic [7:0] OPC_READ_FAST = 8'h0B;
  localparam logic [7:0] OPC_READ_SLOW = 8'h03;
  localparam logic [7:0] OPC_READ_DUAL = 8'h3B;
  localparam logic [7:0] OPC_PROG_DUAL = 8'hA2;
  localparam logic [7:0] OPC_READ_OTP = 8'h77;

  function automatic logic op_supported(input logic [7:0] op);
    case (op)
      8'h1B, 8'h0B, 8'h03, 8'h3B, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h02, 8'hA2,
      8'hB0, 8'hD0, 8'h06, 8'h04, 8'h36, 8'h39, 8'h3C, 8'h33, 8'h34, 8'h35, 8'h9B,
      8'h77, 8'h05, 8'h01, 8'h31, 8'hF0, 8'h9F, 8'hB9, 8'hAB: op_supported = 1'b1;
      default: op_supported = 1'b0;
    endcase
  endfunction

  function automatic logic op_has_addr(input logic [7:0] op);
    case (op)
      8'h1B, 8'h0B, 8'h03, 8'h3B, 8'h20, 8'h52, 8'hD8, 8'h02, 8'hA2, 8'h36, 8'h39,
      8'h3C, 8'h33, 8'h34, 8'h35, 8'h9B, 8'h77: op_has_addr = 1'b1;
      default: op_has_addr = 1'b0;
    endcase
  endfunction

  function automatic logic [1:0] op_dummy(input logic [7:0] op);
    case (op)
      OPC_READ_FAST2, OPC_READ_OTP: op_dummy = 2'd2;
      OPC_READ_FAST, OPC_READ_DUAL: op_dummy = 2'd1;
      default: op_dummy = 2'd0;
    endcase
  endfunction

  function automatic logic op_reads(input logic [7:0] op);
    case (op)
      8'h1B, 8'h0B, 8'h03, 8'h3B, 8'h3C, 8'h35, 8'h77, 8'h05, 8'h9F: op_reads = 1'b1;
      default: op_reads = 1'b0;
    endcase
  endfunction
endpackage

/* spi_link_if.sv */
// four-wire serial flash link with two two-way data pins
// assumes an idle pull-up on both data wires when nobody drives
`timescale 1ns/1ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic host_io0_o;
  logic host_io0_oe;
  logic host_io1_o;
  logic host_io1_oe;
  logic dev_io0_o;
  logic dev_io0_oe;
  logic dev_io1_o;
  logic dev_io1_oe;
  logic io0;
  logic io1;

  // wire level: the device wins, otherwise the host, otherwise pulled high
  assign io0 = dev_io0_oe ? dev_io0_o : (host_io0_oe ? host_io0_o : 1'b1);
  assign io1 = dev_io1_oe ? dev_io1_o : (host_io1_oe ? host_io1_o : 1'b1);

  modport dev (
    input cs_n,
    input sck,
    input io0,
    input io1,
    output dev_io0_o,
    output dev_io0_oe,
    output dev_io1_o,
    output dev_io1_oe
  );

  modport host (
    output cs_n,
    output sck,
    output host_io0_o,
    output host_io0_oe,
    output host_io1_o,
    output host_io1_oe,
    input io0,
    input io1
  );
endinterface

/* tb.sv */
// bench: host and device joined on one link, a second device driven by hand
// assumes the package constants and a 25 MHz system clock
`timescale 1ns/1ps
module tb;
  import flash_spi_pkg::*;
  logic sys_clk, arst_n, mode3, cmd_start, h_busy, h_done, h_wr_req, h_rd_valid;
  logic d_op_start, d_op_end, d_ign, d_wr_valid, d_rd_req, b_start, b_abort, b_ign, d_busy;
  logic [7:0] cmd_opcode, h_wr_data, d_rd_data, h_rd_data, d_op_code, d_wr_data, nx;
  logic [ADDR_W-1:0] cmd_addr, d_op_addr;
  logic [LEN_W-1:0] cmd_len;
  logic [7:0] wq[$], rq[$];
  logic [31:0] sh;
  logic seen_d0, seen_h1;
  int n_errors = 0, n_checks = 0, nb, n_st, n_end, n_ig, n_wr, n_rd, b_st, b_ab, b_ig, n_done;
  logic [7:0] ops[11] = '{8'h03, 8'h0B, 8'h1B, 8'h3B, 8'h05, 8'h02, 8'hA2, 8'h20, 8'h06,
    8'hC7, 8'hFF};
  int lens[11] = '{1, 2, 2, 2, 1, 2, 2, 0, 0, 0, 0};
  spi_link_if lk();
  spi_link_if lkb();

  flash_spi_host flash_spi_host_inst (.sys_clk, .arst_n, .link(lk.host), .mode3, .cmd_start,
    .cmd_opcode, .cmd_addr, .cmd_len, .busy(h_busy), .done(h_done), .wr_req(h_wr_req),
    .wr_data(h_wr_data), .rd_valid(h_rd_valid), .rd_data(h_rd_data));
  flash_spi_dev flash_spi_dev_inst (.sys_clk, .arst_n, .link(lk.dev), .op_start(d_op_start),
    .op_code(d_op_code), .op_addr(d_op_addr), .op_end(d_op_end), .op_abort(), .op_ignored(d_ign),
    .wr_valid(d_wr_valid), .wr_data(d_wr_data), .rd_req(d_rd_req), .rd_data(d_rd_data),
    .busy(d_busy));
  flash_spi_dev flash_spi_dev_inst_b (.sys_clk, .arst_n, .link(lkb.dev), .op_start(b_start),
    .op_code(), .op_addr(), .op_end(), .op_abort(b_abort), .op_ignored(b_ign), .wr_valid(),
    .wr_data(), .rd_req(), .rd_data(8'h00), .busy());
  flash_spi_asserts flash_spi_asserts_inst (.sys_clk, .arst_n, .cs_n(lk.cs_n), .sck(lk.sck),
    .host_io0_o(lk.host_io0_o), .host_io0_oe(lk.host_io0_oe), .host_io1_o(lk.host_io1_o),
    .host_io1_oe(lk.host_io1_oe), .dev_io0_o(lk.dev_io0_o), .dev_io0_oe(lk.dev_io0_oe),
    .dev_io1_o(lk.dev_io1_o), .dev_io1_oe(lk.dev_io1_oe));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic has_a(input logic [7:0] op);
    return op inside {8'h03, 8'h0B, 8'h1B, 8'h3B, 8'h02, 8'hA2, 8'h20};
  endfunction

  function automatic logic is_rd(input logic [7:0] op);
    return op inside {8'h03, 8'h0B, 8'h1B, 8'h3B, 8'h05};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors=%0d checks=%0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // user-side data sources and sinks, plus pulse counters
  always @(posedge sys_clk) begin
    if (d_op_start === 1'b1) begin
      n_st++;
      chk(d_op_code, cmd_opcode);
      chk(d_op_addr, has_a(cmd_opcode) ? {2'b00, cmd_addr[21:0]} : 24'h00_0000);
    end
    n_end += int'(d_op_end === 1'b1);
    n_done += int'(h_done === 1'b1);
    n_ig += int'(d_ign === 1'b1);
    b_st += int'(b_start === 1'b1);
    b_ab += int'(b_abort === 1'b1);
    b_ig += int'(b_ign === 1'b1);
    seen_d0 |= (lk.dev_io0_oe === 1'b1);
    seen_h1 |= (lk.host_io1_oe === 1'b1);
    if (h_wr_req === 1'b1) begin
      nx = 8'($urandom);
      wq.push_back(nx);
      h_wr_data <= #1 nx;
    end
    if (d_rd_req === 1'b1) begin
      nx = 8'($urandom);
      rq.push_back(nx);
      d_rd_data <= #1 nx;
    end
    if (d_wr_valid === 1'b1) begin
      n_wr++;
      if (wq.size() > 0) chk(d_wr_data, wq.pop_front());
    end
    if (h_rd_valid === 1'b1) begin
      n_rd++;
      if (rq.size() > 0) chk(h_rd_data, rq.pop_front());
    end
  end

  // bits on io0 as the device sees them at rising clock edges
  always @(posedge lk.sck) begin
    if (lk.cs_n === 1'b0 && nb < 32) begin
      sh = {sh[30:0], lk.io0};
      nb++;
    end
  end

  task automatic run_cmd(input logic m, input logic [7:0] op, input logic [23:0] a, input int len);
    int k;
    @(posedge sys_clk);
    wq.delete();
    rq.delete();
    {n_st, n_end, n_ig, n_wr, n_rd, nb, n_done} = '0;
    {seen_d0, seen_h1} = 2'b00;
    // idle level settles a cycle before select falls
    #1 mode3 = m;
    @(posedge sys_clk);
    #1 {cmd_opcode, cmd_addr, cmd_len, cmd_start} = {op, a, LEN_W'(len), 1'b1};
    @(posedge sys_clk);
    #1 cmd_start = 1'b0;
    for (k = 0; k < 4000 && h_busy !== 1'b0; k++) @(posedge sys_clk);
    chk(h_busy, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk(lk.sck, m);
    chk(lk.cs_n, 1'b1);
    chk(n_done, 1);
    chk(d_busy, 1'b0);
    chk(n_st, op != 8'hFF);
    chk(n_end, op != 8'hFF);
    chk(n_ig, op == 8'hFF);
    chk(n_rd, is_rd(op) ? len : 0);
    chk(n_wr, (op != 8'hFF && !is_rd(op)) ? len : 0);
    chk(seen_d0, op == 8'h3B);
    chk(seen_h1, op == 8'hA2);
    if (has_a(op)) chk(sh, {op, a});
    else if (nb == 8) chk(sh[7:0], op);
  endtask

  // hand-driven frame of n bits; select released with the line pulled up
  task automatic bang(input logic [31:0] bits, input int n, input logic [2:0] e);
    {b_st, b_ab, b_ig} = '0;
    @(posedge sys_clk);
    #1 {lkb.cs_n, lkb.host_io0_oe} = 2'b01;
    for (int i = 0; i < n; i++) begin
      lkb.host_io0_o = bits[31-i];
      repeat (SCK_HALF_CYC) @(posedge sys_clk);
      #1 lkb.sck = 1'b1;
      repeat (SCK_HALF_CYC) @(posedge sys_clk);
      #1 lkb.sck = 1'b0;
    end
    repeat (SCK_HALF_CYC) @(posedge sys_clk);
    #1 {lkb.cs_n, lkb.host_io0_oe} = 2'b10;
    repeat (20) @(posedge sys_clk);
    chk(b_ab, e[2]);
    chk(b_ig, e[1]);
    chk(b_st, e[0]);
  endtask

  initial begin
    {arst_n, mode3, cmd_start, cmd_opcode, cmd_addr, cmd_len, h_wr_data, d_rd_data} = '0;
    {lkb.cs_n, lkb.sck, lkb.host_io0_o, lkb.host_io0_oe, lkb.host_io1_o, lkb.host_io1_oe} = 6'h20;
    void'($urandom(72));
    repeat (5) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    foreach (ops[i]) run_cmd(i[0], ops[i], i < 2 ? 24'hFF_FFFF : 24'($urandom), lens[i]);
    repeat (4) begin
      nb = $urandom % 11;
      run_cmd(1'($urandom), ops[nb], 24'($urandom), lens[nb] != 0 ? 2 : 0);
    end
    bang(32'h0300_0000, 4, 3'b100);
    bang(32'h0BC0_0000, 20, 3'b100);
    bang(32'hFF06_0000, 16, 3'b010);
    bang(32'h20C1_2345, 32, 3'b001);
    end_sim();
  end

  // whole run is near 15000 cycles
  initial begin
    #2400000;
    n_errors++;
    end_sim();
  end
endmodule
